// file: inc/lbkt_pkg.sv
// package for the leaky-bucket activity monitor, configuration two
// assumes a 25 mhz system clock and an 8-bit wishbone register window
package lbkt_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CYCLE_MS = 128;
  // cycles per monitoring period, derived from the period and the clock rate
  localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;

  // ****************************************
  // register map (word indices, taken from adr_i[9:2]; printed offsets are indices)
  // ****************************************
  localparam logic [7:0] IDX_LEAK = 8'h5b;
  localparam logic [7:0] IDX_CAP = 8'h5c;
  localparam logic [7:0] IDX_UPPER = 8'h5d;
  localparam logic [7:0] IDX_LOWER = 8'h5e;
  localparam logic [7:0] IDX_STATUS = 8'h5f;
  localparam logic [7:0] IDX_IRQ = 8'h60;
  localparam logic [7:0] IDX_MASK = 8'h61;
  localparam logic [7:0] IDX_COUNT = 8'h62;
  localparam int ADDR_W = 10;

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [1:0] LEAK_RST = 2'h1;
  localparam logic [7:0] CAP_RST = 8'h08;
  localparam logic [7:0] UPPER_RST = 8'h06;
  localparam logic [7:0] LOWER_RST = 8'h04;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam int LEAK_LSB = 0;
  localparam int LEAK_MSB = 1;
  localparam int EV_RAISE = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_SAT = 2;
  localparam int EV_N = 3;

  typedef struct packed {
    logic [1:0] leak;
    logic [7:0] cap;
    logic [7:0] upper;
    logic [7:0] lower;
  } lbkt_cfg_t;

  typedef struct packed {
    logic [7:0] count;
    logic alarm;
  } lbkt_stat_t;
endpackage

// file: testbench/lbkt_top_assertions.sv
// checker of the bucket top: bus answer, read data, alarm causes
// assumes it is bound to lbkt_top and sees only its ports
module lbkt_top_chk #(
  parameter int unsigned CYCLE_CLKS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bad_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lbkt_pkg::ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic alarm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // ****************************************
  // bus and alarm properties
  // ****************************************
  ack_answer_a: assert property (s_req |=> ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  rdata_hold_a: assert property ($changed(dat_o) |-> ack_o && !$past(we_i)) else $error("read data moved");
  leak_bits_a: assert property (ack_o && $past(!we_i && adr_i[9:2] == lbkt_pkg::IDX_LEAK) |->
    dat_o[31:2] == 30'h0) else $error("leak unused bits set");
  byte_wide_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read wider than byte");
  // alarm edges need a tick verdict or a register write just before
  alarm_rise_a: assert property ($rose(alarm_o) |-> $past(bad_i) || $past(bad_i, 2) ||
    $past(cyc_i && we_i) || $past(cyc_i && we_i, 2)) else $error("alarm rose without cause");
  alarm_fall_a: assert property ($fell(alarm_o) |-> !$past(bad_i) || !$past(bad_i, 2) ||
    $past(cyc_i && we_i) || $past(cyc_i && we_i, 2)) else $error("alarm fell without cause");
endmodule
bind lbkt_top lbkt_top_chk #(
  .CYCLE_CLKS(CYCLE_CLKS)
) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .bad_i(bad_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .alarm_o(alarm_o)
);

// file: testbench/tb_top.sv
// bench of the bucket top: wishbone accesses and bucket scenarios
// assumes an 8-clock monitoring period so ticks fall at known phases
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t %h vs %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, bad_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [9:0] adr_i = 10'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, r;
  logic ack_o, alarm_o, irq_o;
  int num_errors = 0, checks = 0, cnt = 0, p;
  always #20 clk_i = ~clk_i;
  lbkt_top #(
    .CYCLE_CLKS(8)
  ) u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bad_i(bad_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .alarm_o(alarm_o),
    .irq_o(irq_o)
  );
  // ****************************************
  // tasks
  // ****************************************
  task stop_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one classic cycle, held until ack is seen at an edge
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'hf};
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h0);
    `CHK(r, {24'h0, e})
  endtask
  // level on bad_i for n periods, switched mid-period away from ticks
  task hold(input logic b, input int n);
    while (cnt % 8 != 4) @(posedge clk_i);
    bad_i <= b;
    repeat (n * 8) @(posedge clk_i);
  endtask
  // timeout well above the roughly 1000 cycles of the run
  always @(posedge clk_i) begin
    cnt <= rst_i ? 0 : cnt + 1;
    if (cnt == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lbkt_pkg::IDX_LEAK, 8'h01);
    rd(lbkt_pkg::IDX_CAP, 8'h08);
    rd(lbkt_pkg::IDX_COUNT, 8'h00);
    rd(8'h70, 8'h00);
    rd(lbkt_pkg::IDX_UPPER, 8'h06);
    rd(lbkt_pkg::IDX_LOWER, 8'h04);
    rd(lbkt_pkg::IDX_STATUS, 8'h00);
    wb(1'b1, lbkt_pkg::IDX_LEAK, 8'hff);
    rd(lbkt_pkg::IDX_LEAK, 8'h03);
    wb(1'b1, lbkt_pkg::IDX_MASK, 8'h01);
    for (int c = 0; c < 4; c++) begin
      p = 1 << c;
      wb(1'b1, lbkt_pkg::IDX_LEAK, c[7:0]);
      hold(1'b1, 10);
      rd(lbkt_pkg::IDX_COUNT, 8'h08);
      `CHK(alarm_o, 1'b1)
      // alarm never falls in this loop, so only the first pass raises it
      `CHK(irq_o, c == 0)
      wb(1'b0, lbkt_pkg::IDX_IRQ, 8'h0);
      `CHK(r, (c == 0) ? 32'h05 : 32'h04)
      `CHK(irq_o, 1'b0)
      hold(1'b0, 2 * p);
      rd(lbkt_pkg::IDX_COUNT, 8'h06);
      `CHK(alarm_o, 1'b1)
    end
    rd(lbkt_pkg::IDX_STATUS, 8'h01);
    hold(1'b0, 4);
    hold(1'b1, 1);
    hold(1'b0, 7);
    rd(lbkt_pkg::IDX_COUNT, 8'h07);
    wb(1'b1, lbkt_pkg::IDX_LEAK, 8'h00);
    hold(1'b0, 10);
    rd(lbkt_pkg::IDX_COUNT, 8'h00);
    `CHK(alarm_o, 1'b0)
    rd(lbkt_pkg::IDX_STATUS, 8'h00);
    wb(1'b1, lbkt_pkg::IDX_CAP, 8'h03);
    hold(1'b1, 5);
    rd(lbkt_pkg::IDX_COUNT, 8'h03);
    stop_test();
  end
endmodule

// file: verilog/lbkt_bucket.sv
// accumulator core: fill, leak, saturation and alarm hysteresis
// assumes tick_i is a one-cycle pulse per monitoring period
module lbkt_bucket (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic bad_i,
  input wire lbkt_pkg::lbkt_cfg_t cfg_i,
  output lbkt_pkg::lbkt_stat_t stat_o,
  output logic [lbkt_pkg::EV_N-1:0] ev_o
);
  logic [7:0] acc_q;
  logic [2:0] quiet_q;
  logic alarm_q;
  logic [7:0] acc_d;
  logic leak_now;
  logic [2:0] quiet_last;

  // leak code picks 1, 2, 4 or 8 quiet cycles
  always_comb begin
    case (cfg_i.leak)
      2'h0: quiet_last = 3'h0; // RULE2
      2'h1: quiet_last = 3'h1; // RULE2
      2'h2: quiet_last = 3'h3; // RULE3
      default: quiet_last = 3'h7; // RULE3
    endcase
    leak_now = (quiet_q >= quiet_last);
  end

  // next count; capacity may be lowered below the count, so clamp always
  always_comb begin
    acc_d = acc_q;
    if (tick_i && bad_i) begin
      acc_d = (acc_q >= cfg_i.cap) ? cfg_i.cap : acc_q + 8'h1; // RULE1 RULE5
    end else if (tick_i && leak_now && acc_q != 8'h0) begin
      acc_d = acc_q - 8'h1; // RULE2 RULE8
    end
    if (acc_d > cfg_i.cap) begin
      acc_d = cfg_i.cap; // RULE5
    end
  end

  // accumulator and quiet-cycle counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 8'h00;
      quiet_q <= 3'h0;
    end else begin
      acc_q <= acc_d;
      if (tick_i) begin
        if (bad_i || leak_now) begin
          quiet_q <= 3'h0; // RULE8
        end else begin
          quiet_q <= quiet_q + 3'h1;
        end
      end
    end
  end

  // alarm hysteresis; raise takes priority if thresholds overlap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else if (acc_d >= cfg_i.upper) begin
      alarm_q <= 1'b1; // RULE6
    end else if (acc_d <= cfg_i.lower) begin
      alarm_q <= 1'b0; // RULE7
    end
  end

  // event pulses, aligned with the register update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_o <= '0;
    end else begin
      ev_o[lbkt_pkg::EV_RAISE] <= !alarm_q && (acc_d >= cfg_i.upper);
      ev_o[lbkt_pkg::EV_CLEAR] <= alarm_q && (acc_d < cfg_i.upper) && (acc_d <= cfg_i.lower);
      ev_o[lbkt_pkg::EV_SAT] <= tick_i && bad_i && (acc_q >= cfg_i.cap);
    end
  end

  assign stat_o.count = acc_q;
  assign stat_o.alarm = alarm_q;
endmodule

// file: verilog/lbkt_tick.sv
// cycle divider: one-cycle enable at the end of each monitoring period
// assumes a single clock and synchronous active-high reset
module lbkt_tick #(
  parameter int unsigned PERIOD = lbkt_pkg::CYCLE_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_q;

  // free-running period counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: verilog/lbkt_top.sv
// top of the leaky-bucket activity monitor with its wishbone register file
// assumes classic wishbone, 32-bit data, byte addresses, one clock
//
// ****************************************
// top module
// ****************************************
// How it works
// RULE1 - once per 128 ms cycle, a failed or erratic input adds one
// RULE2 - leak code 00 drains one per quiet cycle, 01 per two
// RULE3 - leak code 10 drains one per four quiet cycles, 11 per eight
// RULE4 - leak code sits in bits 1:0; bits 7:2 read zero
// RULE5 - count saturates at the 8-bit programmable capacity
// RULE6 - count reaching upper threshold raises the inactivity alarm
// RULE7 - count falling to lower threshold clears the inactivity alarm
// RULE8 - no drain below zero; a bad cycle restarts the quiet count
//
// Added by the designer: the Wishbone interface to the registers.
module lbkt_top #(
  parameter int unsigned CYCLE_CLKS = lbkt_pkg::CYCLE_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bad_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lbkt_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic alarm_o,
  output logic irq_o
);
  lbkt_pkg::lbkt_cfg_t cfg_q;
  lbkt_pkg::lbkt_stat_t stat;
  logic [lbkt_pkg::EV_N-1:0] ev;
  logic [lbkt_pkg::EV_N-1:0] irq_q;
  logic [lbkt_pkg::EV_N-1:0] mask_q;
  logic tick;
  logic req;
  logic wr;
  logic rd_irq;
  logic [7:0] idx;
  logic [31:0] rdata;

  // ****************************************
  // datapath
  // ****************************************
  lbkt_tick #(
    .PERIOD(CYCLE_CLKS)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  lbkt_bucket u_bucket (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .bad_i(bad_i),
    .cfg_i(cfg_q),
    .stat_o(stat),
    .ev_o(ev)
  );

  // ****************************************
  // wishbone slave
  // ****************************************
  // one-cycle-late ack; ack drops the cycle after so no double access
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign idx = adr_i[lbkt_pkg::ADDR_W-1:2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // config writes; only byte lane 0 holds data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q.leak <= lbkt_pkg::LEAK_RST;
      cfg_q.cap <= lbkt_pkg::CAP_RST;
      cfg_q.upper <= lbkt_pkg::UPPER_RST;
      cfg_q.lower <= lbkt_pkg::LOWER_RST;
      mask_q <= lbkt_pkg::MASK_RST[lbkt_pkg::EV_N-1:0];
    end else if (wr) begin
      case (idx)
        lbkt_pkg::IDX_LEAK: cfg_q.leak <= dat_i[lbkt_pkg::LEAK_MSB:lbkt_pkg::LEAK_LSB]; // RULE4
        lbkt_pkg::IDX_CAP: cfg_q.cap <= dat_i[7:0]; // RULE5
        lbkt_pkg::IDX_UPPER: cfg_q.upper <= dat_i[7:0];
        lbkt_pkg::IDX_LOWER: cfg_q.lower <= dat_i[7:0];
        lbkt_pkg::IDX_MASK: mask_q <= dat_i[lbkt_pkg::EV_N-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads return zero with a normal ack
  always_comb begin
    case (idx)
      lbkt_pkg::IDX_LEAK: rdata = {30'h0, cfg_q.leak}; // RULE4
      lbkt_pkg::IDX_CAP: rdata = {24'h0, cfg_q.cap};
      lbkt_pkg::IDX_UPPER: rdata = {24'h0, cfg_q.upper};
      lbkt_pkg::IDX_LOWER: rdata = {24'h0, cfg_q.lower};
      lbkt_pkg::IDX_STATUS: rdata = {31'h0, stat.alarm};
      lbkt_pkg::IDX_IRQ: rdata = {29'h0, irq_q};
      lbkt_pkg::IDX_MASK: rdata = {29'h0, mask_q};
      lbkt_pkg::IDX_COUNT: rdata = {24'h0, stat.count};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req && !we_i) begin
      dat_o <= rdata;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // read clears the sticky bits; a new event in the same cycle survives
  assign rd_irq = req && !we_i && (idx == lbkt_pkg::IDX_IRQ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= '0;
    end else begin
      irq_q <= (rd_irq ? '0 : irq_q) | ev;
    end
  end

  assign irq_o = |(irq_q & mask_q);
  assign alarm_o = stat.alarm;
endmodule
